/* File: tmwoc_map.svh */
// Register offsets, field positions, reset values and mode codes of the waveform timer.
`ifndef TMWOC_MAP_SVH
`define TMWOC_MAP_SVH

`define TMWOC_ADR_CTL_A     8'h00
`define TMWOC_ADR_CTL_B     8'h04
`define TMWOC_ADR_MATCH_A   8'h08
`define TMWOC_ADR_MATCH_B   8'h0c
`define TMWOC_ADR_COUNT     8'h10
`define TMWOC_ADR_STATUS    8'h14
`define TMWOC_ADR_MASK      8'h18
`define TMWOC_ADR_PORT_DIR  8'h1c
`define TMWOC_ADR_PORT_DATA 8'h20

`define TMWOC_OMA_HI        7
`define TMWOC_OMA_LO        6
`define TMWOC_OMB_HI        5
`define TMWOC_OMB_LO        4
`define TMWOC_WML_HI        1
`define TMWOC_WML_LO        0
`define TMWOC_CTLB_WMH      3
`define TMWOC_CTLB_RUN      0
`define TMWOC_CTL_A_WMASK   8'hf3

`define TMWOC_ST_OVF        0
`define TMWOC_ST_MA         1
`define TMWOC_ST_MB         2
`define TMWOC_PIN_A         0
`define TMWOC_PIN_B         1

`define TMWOC_RST_BYTE      8'h00
`define TMWOC_RST_WORD      32'h0000_0000
`define TMWOC_MAX           8'hff
`define TMWOC_BOTTOM        8'h00
`define TMWOC_ONE           8'h01

`define TMWOC_MODE_NORMAL   3'h0
`define TMWOC_MODE_PC_FF    3'h1
`define TMWOC_MODE_CTC      3'h2
`define TMWOC_MODE_FAST_FF  3'h3
`define TMWOC_MODE_RSV4     3'h4
`define TMWOC_MODE_PC_MA    3'h5
`define TMWOC_MODE_RSV6     3'h6
`define TMWOC_MODE_FAST_MA  3'h7

`endif

/* File: tmwoc_pkg.sv */
// Types shared by the waveform timer design.
package tmwoc_pkg;

    typedef enum logic [2:0] {
        KIND_NORMAL,
        KIND_CTC,
        KIND_FAST,
        KIND_PHASE,
        KIND_HOLD
    } tmwoc_kind_type;

    typedef struct packed {
        logic [7:0]  ctl_a;
        logic        hi_bit;
        logic        run;
        logic [7:0]  buf_a;
        logic [7:0]  buf_b;
        logic [7:0]  act_a;
        logic [7:0]  act_b;
        logic [7:0]  cnt;
        logic        down;
        logic        wave_a;
        logic        wave_b;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic [1:0]  dir;
        logic [1:0]  port;
        logic        pin_a;
        logic        pin_b;
        logic        oe_a;
        logic        oe_b;
        logic        ack;
        logic [31:0] dat;
        logic        irq;
    } tmwoc_state_type;

endpackage : tmwoc_pkg

/* File: tmwoc_top.sv */
// Eight-bit waveform timer with output mode decode behind a classic Wishbone slave.
`timescale 1ns/1ps
`include "tmwoc_map.svh"

module tmwoc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    output logic             wave_out_pin_a_o,
    output logic             wave_out_pin_a_oe_o,
    output logic             wave_out_pin_b_o,
    output logic             wave_out_pin_b_oe_o
);

    tmwoc_pkg::tmwoc_state_type st_ff;
    tmwoc_pkg::tmwoc_state_type nxt_st;

    function automatic tmwoc_pkg::tmwoc_kind_type mode_kind(input logic [2:0] mode);
        tmwoc_pkg::tmwoc_kind_type k;
        k = tmwoc_pkg::KIND_HOLD;
        unique case (mode)
            `TMWOC_MODE_NORMAL:  k = tmwoc_pkg::KIND_NORMAL;
            `TMWOC_MODE_CTC:     k = tmwoc_pkg::KIND_CTC;
            `TMWOC_MODE_FAST_FF: k = tmwoc_pkg::KIND_FAST;
            `TMWOC_MODE_FAST_MA: k = tmwoc_pkg::KIND_FAST;
            `TMWOC_MODE_PC_FF:   k = tmwoc_pkg::KIND_PHASE;
            `TMWOC_MODE_PC_MA:   k = tmwoc_pkg::KIND_PHASE;
            `TMWOC_MODE_RSV4:    k = tmwoc_pkg::KIND_HOLD;
            `TMWOC_MODE_RSV6:    k = tmwoc_pkg::KIND_HOLD;
        endcase
        return k;
    endfunction : mode_kind

    function automatic logic [7:0] top_of(input logic [2:0] mode, input logic [7:0] act_a);
        logic [7:0] t;
        t = `TMWOC_MAX;
        if (mode == `TMWOC_MODE_CTC || mode == `TMWOC_MODE_PC_MA ||
            mode == `TMWOC_MODE_FAST_MA) begin
            t = act_a;
        end
        return t;
    endfunction : top_of

    // One channel's next output level for a single count step.
    function automatic logic chan_next(
        input logic                      wave,
        input logic [1:0]                fld,
        input logic                      is_a,
        input tmwoc_pkg::tmwoc_kind_type kind,
        input logic                      hi,
        input logic                      match,
        input logic                      at_top,
        input logic                      at_bottom,
        input logic                      down,
        input logic                      act_is_top
    );
        logic w;
        logic special;
        logic toggle_ok;
        w = wave;
        special = act_is_top && fld[1];
        toggle_ok = is_a && hi && (fld == 2'b01);
        unique case (kind)
            tmwoc_pkg::KIND_NORMAL,
            tmwoc_pkg::KIND_CTC: begin
                if (match) begin
                    unique case (fld)
                        2'b00: w = wave;
                        2'b01: w = ~wave;
                        2'b10: w = 1'b0;
                        2'b11: w = 1'b1;
                    endcase
                end
            end
            tmwoc_pkg::KIND_FAST: begin
                if (fld[1]) begin
                    if (at_bottom) begin
                        w = ~fld[0];
                    end
                    if (match && !special) begin
                        w = fld[0];
                    end
                end else if (toggle_ok && match) begin
                    w = ~wave;
                end
            end
            tmwoc_pkg::KIND_PHASE: begin
                if (fld[1]) begin
                    if (special) begin
                        if (at_top) begin
                            w = ~fld[0];
                        end
                    end else if (match) begin
                        w = down ? ~fld[0] : fld[0];
                    end
                end else if (toggle_ok && match) begin
                    w = ~wave;
                end
            end
            tmwoc_pkg::KIND_HOLD: begin
                w = wave;
            end
        endcase
        return w;
    endfunction : chan_next

    logic [2:0]                mode;
    tmwoc_pkg::tmwoc_kind_type kind;
    logic [7:0]                top;
    logic                      tick;
    logic                      at_top;
    logic                      at_bottom;
    logic                      at_max;
    logic                      match_a;
    logic                      match_b;
    logic                      ovf_hit;
    logic                      bus_hit;
    logic                      wr_go;
    logic [7:0]                wbyte;
    logic [7:0]                rbyte;
    logic [7:0]                ctl_b_rd;
    logic [2:0]                w1c;

    always_comb begin
        nxt_st = st_ff;
        mode = {st_ff.hi_bit, st_ff.ctl_a[`TMWOC_WML_HI:`TMWOC_WML_LO]};
        kind = mode_kind(mode);
        top = top_of(mode, st_ff.act_a);
        tick = st_ff.run && (kind != tmwoc_pkg::KIND_HOLD);
        at_top = (st_ff.cnt == top);
        at_bottom = (st_ff.cnt == `TMWOC_BOTTOM);
        at_max = (st_ff.cnt == `TMWOC_MAX);
        match_a = tick && (st_ff.cnt == st_ff.act_a);
        match_b = tick && (st_ff.cnt == st_ff.act_b);

        // Counting sequence.
        if (tick) begin
            unique case (kind)
                tmwoc_pkg::KIND_NORMAL: begin
                    nxt_st.cnt = st_ff.cnt + `TMWOC_ONE;
                    nxt_st.down = 1'b0;
                end
                tmwoc_pkg::KIND_CTC,
                tmwoc_pkg::KIND_FAST: begin
                    nxt_st.cnt = at_top ? `TMWOC_BOTTOM : st_ff.cnt + `TMWOC_ONE;
                    nxt_st.down = 1'b0;
                end
                tmwoc_pkg::KIND_PHASE: begin
                    // A TOP of zero would otherwise bounce through 0xff.
                    if (at_top && at_bottom) begin
                        nxt_st.cnt = `TMWOC_BOTTOM;
                    end else if (!st_ff.down) begin
                        if (at_top) begin
                            nxt_st.down = 1'b1;
                            nxt_st.cnt = st_ff.cnt - `TMWOC_ONE;
                        end else begin
                            nxt_st.cnt = st_ff.cnt + `TMWOC_ONE;
                        end
                    end else begin
                        if (at_bottom) begin
                            nxt_st.down = 1'b0;
                            nxt_st.cnt = st_ff.cnt + `TMWOC_ONE;
                        end else begin
                            nxt_st.cnt = st_ff.cnt - `TMWOC_ONE;
                        end
                    end
                end
                tmwoc_pkg::KIND_HOLD: begin
                    nxt_st.cnt = st_ff.cnt;
                end
            endcase
        end

        // Overflow moment per mode.
        ovf_hit = 1'b0;
        if (tick) begin
            unique case (mode)
                `TMWOC_MODE_NORMAL,
                `TMWOC_MODE_CTC,
                `TMWOC_MODE_FAST_FF: ovf_hit = at_max;
                `TMWOC_MODE_PC_FF,
                `TMWOC_MODE_PC_MA:   ovf_hit = st_ff.down && at_bottom;
                `TMWOC_MODE_FAST_MA: ovf_hit = at_top;
                `TMWOC_MODE_RSV4,
                `TMWOC_MODE_RSV6:    ovf_hit = 1'b0;
            endcase
        end

        // Waveform outputs.
        if (tick) begin
            nxt_st.wave_a = chan_next(st_ff.wave_a,
                                      st_ff.ctl_a[`TMWOC_OMA_HI:`TMWOC_OMA_LO], 1'b1,
                                      kind, st_ff.hi_bit, match_a, at_top,
                                      at_bottom, st_ff.down, st_ff.act_a == top);
            nxt_st.wave_b = chan_next(st_ff.wave_b,
                                      st_ff.ctl_a[`TMWOC_OMB_HI:`TMWOC_OMB_LO], 1'b0,
                                      kind, st_ff.hi_bit, match_b, at_top,
                                      at_bottom, st_ff.down, st_ff.act_b == top);
        end

        // Compare value takes effect per mode; PWM modes hold it back to avoid glitches.
        unique case (kind)
            tmwoc_pkg::KIND_NORMAL,
            tmwoc_pkg::KIND_CTC,
            tmwoc_pkg::KIND_HOLD: begin
                nxt_st.act_a = st_ff.buf_a;
                nxt_st.act_b = st_ff.buf_b;
            end
            tmwoc_pkg::KIND_PHASE: begin
                if (tick && at_top && !st_ff.down) begin
                    nxt_st.act_a = st_ff.buf_a;
                    nxt_st.act_b = st_ff.buf_b;
                end
            end
            tmwoc_pkg::KIND_FAST: begin
                if (tick && at_top) begin
                    nxt_st.act_a = st_ff.buf_a;
                    nxt_st.act_b = st_ff.buf_b;
                end
            end
        endcase

        // Wishbone slave: read data latched with ack, write applied at the acked edge.
        bus_hit = wb_cyc_i && wb_stb_i;
        nxt_st.ack = bus_hit && !st_ff.ack;
        wr_go = st_ff.ack && bus_hit && wb_we_i && wb_sel_i[0];
        wbyte = wb_dat_i[7:0];
        w1c = 3'h0;
        ctl_b_rd = `TMWOC_RST_BYTE;
        ctl_b_rd[`TMWOC_CTLB_WMH] = st_ff.hi_bit;
        ctl_b_rd[`TMWOC_CTLB_RUN] = st_ff.run;
        rbyte = `TMWOC_RST_BYTE;
        unique case (wb_adr_i)
            `TMWOC_ADR_CTL_A:     rbyte = st_ff.ctl_a & `TMWOC_CTL_A_WMASK;
            `TMWOC_ADR_CTL_B:     rbyte = ctl_b_rd;
            `TMWOC_ADR_MATCH_A:   rbyte = st_ff.buf_a;
            `TMWOC_ADR_MATCH_B:   rbyte = st_ff.buf_b;
            `TMWOC_ADR_COUNT:     rbyte = st_ff.cnt;
            `TMWOC_ADR_STATUS:    rbyte = {5'h00, st_ff.status};
            `TMWOC_ADR_MASK:      rbyte = {5'h00, st_ff.mask};
            `TMWOC_ADR_PORT_DIR:  rbyte = {6'h00, st_ff.dir};
            `TMWOC_ADR_PORT_DATA: rbyte = {6'h00, st_ff.port};
            default:              rbyte = `TMWOC_RST_BYTE;
        endcase
        if (bus_hit && !st_ff.ack) begin
            nxt_st.dat = {24'h000000, rbyte};
        end

        if (wr_go) begin
            unique case (wb_adr_i)
                `TMWOC_ADR_CTL_A: begin
                    nxt_st.ctl_a = wbyte & `TMWOC_CTL_A_WMASK;
                end
                `TMWOC_ADR_CTL_B: begin
                    nxt_st.hi_bit = wbyte[`TMWOC_CTLB_WMH];
                    nxt_st.run = wbyte[`TMWOC_CTLB_RUN];
                end
                `TMWOC_ADR_MATCH_A:   nxt_st.buf_a = wbyte;
                `TMWOC_ADR_MATCH_B:   nxt_st.buf_b = wbyte;
                `TMWOC_ADR_COUNT:     nxt_st.cnt = wbyte;
                `TMWOC_ADR_STATUS:    w1c = wbyte[2:0];
                `TMWOC_ADR_MASK:      nxt_st.mask = wbyte[2:0];
                `TMWOC_ADR_PORT_DIR:  nxt_st.dir = wbyte[1:0];
                `TMWOC_ADR_PORT_DATA: nxt_st.port = wbyte[1:0];
                default: begin
                    nxt_st.mask = st_ff.mask;
                end
            endcase
        end

        // Sticky events; a new event in the clearing cycle survives the clear.
        nxt_st.status = st_ff.status & ~w1c;
        nxt_st.status[`TMWOC_ST_OVF] = nxt_st.status[`TMWOC_ST_OVF] | ovf_hit;
        nxt_st.status[`TMWOC_ST_MA] = nxt_st.status[`TMWOC_ST_MA] | match_a;
        nxt_st.status[`TMWOC_ST_MB] = nxt_st.status[`TMWOC_ST_MB] | match_b;
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);

        // Pin mux; the driver itself is only enabled by software's direction bit.
        nxt_st.pin_a = (|nxt_st.ctl_a[`TMWOC_OMA_HI:`TMWOC_OMA_LO]) ?
                       nxt_st.wave_a : nxt_st.port[`TMWOC_PIN_A];
        nxt_st.pin_b = (|nxt_st.ctl_a[`TMWOC_OMB_HI:`TMWOC_OMB_LO]) ?
                       nxt_st.wave_b : nxt_st.port[`TMWOC_PIN_B];
        nxt_st.oe_a = nxt_st.dir[`TMWOC_PIN_A];
        nxt_st.oe_b = nxt_st.dir[`TMWOC_PIN_B];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign irq_o = st_ff.irq;
    assign wave_out_pin_a_o = st_ff.pin_a;
    assign wave_out_pin_a_oe_o = st_ff.oe_a;
    assign wave_out_pin_b_o = st_ff.pin_b;
    assign wave_out_pin_b_oe_o = st_ff.oe_b;

endmodule : tmwoc_top

/* File: tmwoc_props.sv */
// Checker for the waveform timer, bound to the top module ports.
`timescale 1ns/1ps
`include "tmwoc_map.svh"
module tmwoc_props (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        irq_o,
    input  wire logic        wave_out_pin_a_o,
    input  wire logic        wave_out_pin_a_oe_o,
    input  wire logic        wave_out_pin_b_o,
    input  wire logic        wave_out_pin_b_oe_o
);
    logic [7:0] ctl_ff;
    logic       hi_ff;
    logic [1:0] port_ff;
    logic       wr;
    logic       dir_wr;
    logic       nonpwm;
    // Shadow copies follow accepted writes so pin checks need no internal state.
    assign wr     = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    assign dir_wr = wr & (wb_adr_i == `TMWOC_ADR_PORT_DIR);
    assign nonpwm = !hi_ff && !ctl_ff[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_ff  <= 8'h00;
            hi_ff   <= 1'h0;
            port_ff <= 2'h0;
        end else if (wr) begin
            case (wb_adr_i)
                `TMWOC_ADR_CTL_A:     ctl_ff  <= wb_dat_i[7:0];
                `TMWOC_ADR_CTL_B:     hi_ff   <= wb_dat_i[`TMWOC_CTLB_WMH];
                `TMWOC_ADR_PORT_DATA: port_ff <= wb_dat_i[1:0];
                default:              ;
            endcase
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack_answer;
        s_req |=> s_ans;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack not a one-cycle answer");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_hi_zero;
        wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero");
    property p_rsv_zero;
        wb_ack_o && !wb_we_i && wb_adr_i == `TMWOC_ADR_CTL_A |-> wb_dat_o[3:2] == 2'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");
    property p_ctl_back;
        wb_ack_o && !wb_we_i && wb_adr_i == `TMWOC_ADR_CTL_A
            |-> wb_dat_o[7:0] == (ctl_ff & `TMWOC_CTL_A_WMASK);
    endproperty
    a_ctl_back: assert property (p_ctl_back) else $error("control readback wrong");
    property p_oe_cause;
        $changed({wave_out_pin_a_oe_o, wave_out_pin_b_oe_o}) |-> $past(dir_wr) || $past(dir_wr, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("enable moved without write");
    property p_port_a;
        ctl_ff[7:6] == 2'h0 && $stable(ctl_ff) && $stable(port_ff) |-> wave_out_pin_a_o == port_ff[0];
    endproperty
    a_port_a: assert property (p_port_a) else $error("pin a not port data");
    property p_clr_a;
        nonpwm && ctl_ff[7:6] == 2'h2 && $stable(ctl_ff) && $stable(hi_ff) |-> !$rose(wave_out_pin_a_o);
    endproperty
    a_clr_a: assert property (p_clr_a) else $error("pin a rose in clear mode");
    property p_set_b;
        nonpwm && ctl_ff[5:4] == 2'h3 && $stable(ctl_ff) && $stable(hi_ff) |-> !$fell(wave_out_pin_b_o);
    endproperty
    a_set_b: assert property (p_set_b) else $error("pin b fell in set mode");
endmodule : tmwoc_props

bind tmwoc_top tmwoc_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .wave_out_pin_a_o, .wave_out_pin_a_oe_o,
    .wave_out_pin_b_o, .wave_out_pin_b_oe_o);

/* File: tmwoc_load.sv */
// External load on the two waveform pins.
`timescale 1ns/1ps
module tmwoc_load (
    input  wire logic drv_a_i,
    input  wire logic oe_a_i,
    input  wire logic drv_b_i,
    input  wire logic oe_b_i,
    output logic      line_a_o,
    output logic      line_b_o
);
    // The load has a pull-down, so an undriven pin reads low, never its last level.
    assign line_a_o = oe_a_i ? drv_a_i : 1'h0;
    assign line_b_o = oe_b_i ? drv_b_i : 1'h0;
endmodule : tmwoc_load

/* File: tmwoc_top_tb.sv */
// Self-checking bench for the waveform timer.
`timescale 1ns/1ps
`include "tmwoc_map.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tmwoc_top_tb;
    logic        clk_i = 1'h0, rst_i = 1'h1;
    logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic        wb_ack_o, irq_o, pa, pa_oe, pb, pb_oe, line_a, line_b;
    int          total_checks = 0, miscompares = 0;
    initial forever #12.5 clk_i = ~clk_i;
    tmwoc_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .wave_out_pin_a_o(pa),
        .wave_out_pin_a_oe_o(pa_oe), .wave_out_pin_b_o(pb), .wave_out_pin_b_oe_o(pb_oe));
    tmwoc_load u_load (.drv_a_i(pa), .oe_a_i(pa_oe), .drv_b_i(pb), .oe_b_i(pb_oe),
        .line_a_o(line_a), .line_b_o(line_b));
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= wd;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (wb_ack_o !== 1'h1) begin
            miscompares++;
            final_report();
        end
    endtask : wb
    // Matches are loaded while stopped in mode 0, so buffered updates are already live.
    task automatic setup(input logic [7:0] ctl, input logic hi, input logic [7:0] ma, mb);
        wb(1'h1, `TMWOC_ADR_CTL_B, 32'h0);
        wb(1'h1, `TMWOC_ADR_CTL_A, 32'h0);
        wb(1'h1, `TMWOC_ADR_MATCH_A, {24'h0, ma});
        wb(1'h1, `TMWOC_ADR_MATCH_B, {24'h0, mb});
        wb(1'h1, `TMWOC_ADR_COUNT, 32'h0);
        wb(1'h1, `TMWOC_ADR_CTL_A, {24'h0, ctl});
        wb(1'h1, `TMWOC_ADR_CTL_B, hi ? 32'h9 : 32'h1);
    endtask : setup
    task automatic duty(input int n, input int ea, input int eb);
        int ca, cb;
        ca = 0;
        cb = 0;
        repeat (n) begin
            @(negedge clk_i);
            ca += line_a;
            cb += line_b;
        end
        `CHK("duty a", ea, ca)
        `CHK("duty b", eb, cb)
    endtask : duty
    task automatic t_regs;
        wb(1'h0, `TMWOC_ADR_CTL_A, 32'h0);
        `CHK("ctl reset", 32'h0, rd)
        wb(1'h1, `TMWOC_ADR_CTL_A, 32'hff);
        wb(1'h0, `TMWOC_ADR_CTL_A, 32'h0);
        `CHK("ctl reserved", 32'hf3, rd)
        wb(1'h1, `TMWOC_ADR_CTL_B, 32'h8);
        wb(1'h0, `TMWOC_ADR_CTL_B, 32'h0);
        `CHK("high mode bit", 32'h8, rd)
        wb(1'h1, 8'h24, 32'hff);
        wb(1'h0, 8'h24, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        wb(1'h1, `TMWOC_ADR_CTL_A, 32'h0);
        wb(1'h1, `TMWOC_ADR_CTL_B, 32'h0);
    endtask : t_regs
    task automatic t_pins;
        wb(1'h1, `TMWOC_ADR_PORT_DATA, 32'h2);
        wb(1'h1, `TMWOC_ADR_PORT_DIR, 32'h3);
        repeat (2) @(posedge clk_i);
        `CHK("port a", 1'h0, line_a)
        `CHK("port b", 1'h1, line_b)
        wb(1'h1, `TMWOC_ADR_PORT_DIR, 32'h0);
        repeat (2) @(posedge clk_i);
        `CHK("released b", 1'h0, line_b)
        wb(1'h1, `TMWOC_ADR_PORT_DIR, 32'h3);
    endtask : t_pins
    task automatic t_nonpwm;
        int n;
        logic last;
        setup(8'he0, 1'h0, 8'h05, 8'h05);
        repeat (300) @(posedge clk_i);
        `CHK("set a", 1'h1, line_a)
        `CHK("clear b", 1'h0, line_b)
        wb(1'h1, `TMWOC_ADR_CTL_A, 32'hb0);
        repeat (300) @(posedge clk_i);
        `CHK("clear a", 1'h0, line_a)
        `CHK("set b", 1'h1, line_b)
        wb(1'h1, `TMWOC_ADR_CTL_A, 32'h40);
        @(posedge clk_i);
        n = 0;
        last = line_a;
        repeat (512) begin
            @(negedge clk_i);
            n += (line_a !== last);
            last = line_a;
        end
        `CHK("toggles", 2, n)
    endtask : t_nonpwm
    task automatic t_ctc;
        setup(8'h02, 1'h0, 8'h09, 8'h00);
        wb(1'h1, `TMWOC_ADR_MASK, 32'h2);
        repeat (3) begin
            wb(1'h0, `TMWOC_ADR_COUNT, 32'h0);
            `CHK("ctc top", 1'h1, rd[7:0] <= 8'h09)
        end
        `CHK("irq raised", 1'h1, irq_o)
        wb(1'h1, `TMWOC_ADR_STATUS, 32'h7);
        repeat (300) @(posedge clk_i);
        wb(1'h0, `TMWOC_ADR_STATUS, 32'h0);
        `CHK("no overflow", 3'h6, rd[2:0])
        wb(1'h1, `TMWOC_ADR_MASK, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK("irq masked", 1'h0, irq_o)
        wb(1'h1, `TMWOC_ADR_CTL_B, 32'h0);
        wb(1'h1, `TMWOC_ADR_MASK, 32'h2);
        wb(1'h1, `TMWOC_ADR_STATUS, 32'h7);
        repeat (2) @(posedge clk_i);
        `CHK("irq cleared", 1'h0, irq_o)
    endtask : t_ctc
    task automatic t_pwm;
        for (int f = 2; f < 4; f++) begin
            setup({f[1:0], f[1:0], 4'h3}, 1'h0, 8'hff, 8'h40);
            repeat (260) @(posedge clk_i);
            duty(256, f == 2 ? 256 : 0, f == 2 ? 64 : 192);
            setup({f[1:0], f[1:0], 4'h1}, 1'h0, 8'hff, 8'h40);
            repeat (520) @(posedge clk_i);
            duty(510, f == 2 ? 510 : 0, f == 2 ? 128 : 382);
        end
        setup(8'h63, 1'h1, 8'h3f, 8'h10);
        repeat (70) @(posedge clk_i);
        wb(1'h1, `TMWOC_ADR_STATUS, 32'h7);
        duty(128, 64, 32);
        wb(1'h0, `TMWOC_ADR_STATUS, 32'h0);
        `CHK("top overflow", 1'h1, rd[0])
        setup({2'h2, 2'h2, 4'h1}, 1'h1, 8'h3f, 8'h10);
        repeat (130) @(posedge clk_i);
        duty(126, 126, 32);
        setup(8'h00, 1'h1, 8'h05, 8'h05);
        repeat (10) @(posedge clk_i);
        wb(1'h0, `TMWOC_ADR_COUNT, 32'h0);
        `CHK("reserved holds", 32'h0, rd)
    endtask : t_pwm
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        t_regs();
        t_pins();
        t_nonpwm();
        t_ctc();
        t_pwm();
        final_report();
    end
endmodule : tmwoc_top_tb
